/* logic/ipl_pkg.sv */
// Package: constants shared by both ends of the interprocessor link
package ipl_pkg;
  // ----------------------------------------------------------------
  // Status word bit positions
  // ----------------------------------------------------------------
  localparam int BIT_ERROR     = 15;
  localparam int BIT_MISSING   = 14;
  localparam int BIT_ATTENTION = 13;
  localparam int BIT_XINT      = 11;
  localparam int BIT_IN_DIR    = 10;
  localparam int BIT_IN_MODE   = 9;
  localparam int BIT_CYCLE     = 8;
  localparam int BIT_READY     = 7;
  localparam int BIT_INT_EN    = 6;
  localparam int BIT_OUT_XINT  = 3;
  localparam int BIT_OUT_DIR   = 2;
  localparam int BIT_OUT_MODE  = 1;
  localparam int BIT_GO        = 0;
  localparam logic [15:0] STATUS_RESET = 16'h0080;
  localparam logic [15:0] DATA_RESET   = 16'h0000;
  // ----------------------------------------------------------------
  // Cycle-end interval, microseconds, and clock rate
  // ----------------------------------------------------------------
  localparam int CLK_MHZ        = 250;
  localparam int GAP_MIN_US     = 15;
  localparam int GAP_MID_US     = 50;
  localparam int GAP_MAX_US     = 85;
  localparam int GAP_MIN_CYC    = GAP_MIN_US * CLK_MHZ;
  localparam int GAP_MID_CYC    = GAP_MID_US * CLK_MHZ;
  localparam int GAP_MAX_CYC    = GAP_MAX_US * CLK_MHZ;
  localparam int FIFO_DEPTH     = 8;
  typedef enum logic [2:0] {
    IPL_IDLE = 3'b001,
    IPL_WAIT = 3'b010,
    IPL_SEND = 3'b100
  } ipl_state_e;
endpackage

/* logic/ipl_fifo.sv */
// FIFO module used on the transmit data path
`timescale 1ns/100ps
module ipl_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             CLOCK,
  input  wire logic             NRST,
  input  wire logic             CE,
  input  wire logic             CLR,
  input  wire logic [WIDTH-1:0] IN_DATA,
  input  wire logic             IN_VALID,
  output logic                  IN_READY,
  output logic      [WIDTH-1:0] OUT_DATA,
  output logic                  OUT_VALID,
  input  wire logic             OUT_READY
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;
  assign IN_READY  = (count != (AW+1)'(DEPTH));
  assign OUT_VALID = (count != '0);
  assign push      = IN_VALID && IN_READY;
  assign pop       = OUT_VALID && OUT_READY;
  assign OUT_DATA  = mem[rd_ptr];
  always_ff @(posedge CLOCK) begin
    if (CE && push) begin
      mem[wr_ptr] <= IN_DATA;
    end
  end
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (CE) begin
      if (CLR) begin
        wr_ptr <= '0;
        rd_ptr <= '0;
        count  <= '0;
      end else begin
        if (push) begin
          wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
        end
        if (pop) begin
          rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
        end
        count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
    end
  end
endmodule

/* logic/ipl_link_if.sv */
// Interface joining the two ends of the interprocessor link
`timescale 1ns/100ps
interface ipl_link_if;
  logic [15:0] a_data;
  logic        a_strobe;
  logic        a_init;
  logic        a_xint;
  logic        a_dir;
  logic        a_mode;
  logic        a_present;
  logic [15:0] b_data;
  logic        b_strobe;
  logic        b_init;
  logic        b_xint;
  logic        b_dir;
  logic        b_mode;
  logic        b_present;
  modport end_a (
    output a_data, a_strobe, a_init, a_xint, a_dir, a_mode, a_present,
    input  b_data, b_strobe, b_init, b_xint, b_dir, b_mode, b_present
  );
  modport end_b (
    output b_data, b_strobe, b_init, b_xint, b_dir, b_mode, b_present,
    input  a_data, a_strobe, a_init, a_xint, a_dir, a_mode, a_present
  );
endinterface

/* logic/ipl_end_a.sv */
// Local end of the interprocessor link: status flags, data path, pacing
`timescale 1ns/100ps
module ipl_end_a
  import ipl_pkg::*;
#(
  parameter int GAP_MIN = ipl_pkg::GAP_MIN_CYC,
  parameter int GAP_MID = ipl_pkg::GAP_MID_CYC,
  parameter int GAP_MAX = ipl_pkg::GAP_MAX_CYC
) (
  input  wire logic        CLOCK,
  input  wire logic        NRST,
  input  wire logic        CE,
  input  wire logic        INIT,
  input  wire logic        STAT_WR,
  input  wire logic [15:0] STAT_WDATA,
  output logic      [15:0] STAT_RDATA,
  input  wire logic        DATA_WR,
  input  wire logic [15:0] DATA_WDATA,
  output logic             DATA_WR_READY,
  output logic      [15:0] DATA_RDATA,
  output logic             DATA_RVALID,
  input  wire logic        DATA_RD,
  input  wire logic        MISSING_MEM_EVENT,
  input  wire logic        ADDR_OVF,
  input  wire logic        WC_OVF,
  input  wire logic        TEST_PRESENT,
  input  wire logic [1:0]  GAP_SEL,
  output logic             CYCLE_END,
  output logic             IRQ,
  ipl_link_if.end_a        LINK
);
  import ipl_pkg::*;
  // ----------------------------------------------------------------
  // Latched cause flags and function bits
  // ----------------------------------------------------------------
  logic        err_l, missing_l, xint_l, ready_l;
  logic        int_en, out_xint, out_dir, out_mode, cycle_bit;
  logic        remote_init;
  logic        go;
  logic [15:0] rx_word;
  logic        rx_full;
  assign remote_init = LINK.b_init;
  assign go = STAT_WR && STAT_WDATA[BIT_GO];
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      err_l     <= 1'b0;
      missing_l <= 1'b0;
      xint_l    <= 1'b0;
      ready_l   <= 1'b1;
    end else if (CE) begin
      if (INIT) begin
        err_l     <= 1'b0;
        missing_l <= 1'b0;
        xint_l    <= 1'b0;
        ready_l   <= 1'b1;
      end else begin
        // Sets win over the software clear below
        if (MISSING_MEM_EVENT || ADDR_OVF || !TEST_PRESENT) begin
          err_l <= 1'b1;
        end else if (STAT_WR && !STAT_WDATA[BIT_ERROR]) begin
          err_l <= 1'b0;
        end
        if (MISSING_MEM_EVENT) begin
          missing_l <= 1'b1;
        end else if (STAT_WR && !STAT_WDATA[BIT_MISSING]) begin
          missing_l <= 1'b0;
        end
        if (LINK.b_xint) begin
          xint_l <= 1'b1;
        end else if (STAT_WR && !STAT_WDATA[BIT_XINT]) begin
          xint_l <= 1'b0;
        end
        if (MISSING_MEM_EVENT || ADDR_OVF || !TEST_PRESENT || LINK.b_xint || WC_OVF
            || remote_init) begin
          ready_l <= 1'b1;
        end else if (go) begin
          ready_l <= 1'b0;
        end
      end
    end
  end
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      int_en    <= 1'b0;
      out_xint  <= 1'b0;
      out_dir   <= 1'b0;
      out_mode  <= 1'b0;
      cycle_bit <= 1'b0;
    end else if (CE) begin
      if (INIT) begin
        int_en    <= 1'b0;
        out_xint  <= 1'b0;
        out_dir   <= 1'b0;
        out_mode  <= 1'b0;
        cycle_bit <= 1'b0;
      end else if (STAT_WR) begin
        int_en    <= STAT_WDATA[BIT_INT_EN];
        out_xint  <= STAT_WDATA[BIT_OUT_XINT];
        out_dir   <= STAT_WDATA[BIT_OUT_DIR];
        out_mode  <= STAT_WDATA[BIT_OUT_MODE];
        cycle_bit <= STAT_WDATA[BIT_CYCLE];
      end
    end
  end
  // Error and attention from the remote init follow the pulse only
  always_comb begin
    STAT_RDATA               = 16'h0000;
    STAT_RDATA[BIT_ERROR]    = err_l | remote_init;
    STAT_RDATA[BIT_MISSING]  = missing_l;
    STAT_RDATA[BIT_ATTENTION] = remote_init;
    STAT_RDATA[BIT_XINT]     = xint_l;
    STAT_RDATA[BIT_IN_DIR]   = LINK.b_dir;
    STAT_RDATA[BIT_IN_MODE]  = LINK.b_mode;
    STAT_RDATA[BIT_CYCLE]    = cycle_bit;
    STAT_RDATA[BIT_READY]    = ready_l;
    STAT_RDATA[BIT_INT_EN]   = int_en;
    STAT_RDATA[BIT_OUT_XINT] = out_xint;
    STAT_RDATA[BIT_OUT_DIR]  = out_dir;
    STAT_RDATA[BIT_OUT_MODE] = out_mode;
  end
  assign IRQ = int_en && ready_l;
  // ----------------------------------------------------------------
  // Cycle-end pacing
  // ----------------------------------------------------------------
  logic [31:0] gap_cnt, gap_lim;
  ipl_state_e  state;
  logic        tx_valid, tx_pop;
  logic [15:0] tx_word;
  always_comb begin
    case (GAP_SEL)
      2'h0:    gap_lim = 32'(GAP_MIN);
      2'h1:    gap_lim = 32'(GAP_MID);
      default: gap_lim = 32'(GAP_MAX);
    endcase
  end
  // Word-wide write port only; there is no byte strobe by design
  ipl_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .CLOCK     (CLOCK),
    .NRST      (NRST),
    .CE        (CE),
    .CLR       (INIT),
    .IN_DATA   (DATA_WDATA),
    .IN_VALID  (DATA_WR),
    .IN_READY  (DATA_WR_READY),
    .OUT_DATA  (tx_word),
    .OUT_VALID (tx_valid),
    .OUT_READY (tx_pop)
  );
  assign tx_pop = (state == IPL_SEND);
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      state     <= IPL_IDLE;
      gap_cnt   <= 32'h0000_0000;
      CYCLE_END <= 1'b0;
      LINK.a_data   <= DATA_RESET;
      LINK.a_strobe <= 1'b0;
    end else if (CE) begin
      CYCLE_END     <= 1'b0;
      LINK.a_strobe <= 1'b0;
      if (INIT) begin
        state   <= IPL_IDLE;
        gap_cnt <= 32'h0000_0000;
      end else begin
        case (state)
          IPL_IDLE: if (tx_valid && !out_dir) begin
            state <= IPL_SEND;
          end
          IPL_SEND: begin
            LINK.a_data   <= tx_word;
            LINK.a_strobe <= 1'b1;
            CYCLE_END     <= 1'b1;
            gap_cnt       <= 32'h0000_0001;
            state         <= IPL_WAIT;
          end
          IPL_WAIT: if (gap_cnt >= gap_lim) begin
            state <= IPL_IDLE;
          end else begin
            gap_cnt <= gap_cnt + 32'h0000_0001;
          end
          default: state <= IPL_IDLE;
        endcase
      end
    end
  end
  // ----------------------------------------------------------------
  // Receive word
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      rx_word <= DATA_RESET;
      rx_full <= 1'b0;
    end else if (CE) begin
      if (INIT) begin
        rx_word <= DATA_RESET;
        rx_full <= 1'b0;
      end else if (LINK.b_strobe) begin
        rx_word <= LINK.b_data;
        rx_full <= 1'b1;
      end else if (DATA_RD) begin
        rx_full <= 1'b0;
      end
    end
  end
  assign DATA_RDATA  = rx_word;
  assign DATA_RVALID = rx_full;
  assign LINK.a_init    = INIT;
  assign LINK.a_xint    = out_xint;
  assign LINK.a_dir     = out_dir;
  assign LINK.a_mode    = out_mode;
  assign LINK.a_present = TEST_PRESENT;
endmodule

/* logic/ipl_end_b.sv */
// Companion end of the interprocessor link: word source and sink
`timescale 1ns/100ps
module ipl_end_b
  import ipl_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        NRST,
  input  wire logic        CE,
  input  wire logic        INIT,
  input  wire logic        XINT_REQ,
  input  wire logic        DIR,
  input  wire logic        MODE,
  input  wire logic        SEND,
  input  wire logic [15:0] SEND_DATA,
  output logic      [15:0] RX_DATA,
  output logic             RX_VALID,
  ipl_link_if.end_b        LINK
);
  import ipl_pkg::*;
  // ----------------------------------------------------------------
  // Companion drives its lines from flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      LINK.b_data   <= DATA_RESET;
      LINK.b_strobe <= 1'b0;
      LINK.b_init   <= 1'b0;
      LINK.b_xint   <= 1'b0;
      LINK.b_dir    <= 1'b0;
      LINK.b_mode   <= 1'b0;
      LINK.b_present <= 1'b0;
      RX_DATA       <= DATA_RESET;
      RX_VALID      <= 1'b0;
    end else if (CE) begin
      LINK.b_init    <= INIT;
      LINK.b_xint    <= XINT_REQ;
      LINK.b_dir     <= DIR;          // Software keeps this opposite
      LINK.b_mode    <= MODE;
      LINK.b_present <= 1'b1;
      LINK.b_strobe  <= SEND && !INIT; // Quiet during init; whole words only
      if (SEND) begin
        LINK.b_data <= SEND_DATA;
      end
      RX_VALID <= LINK.a_strobe;
      if (LINK.a_strobe) begin
        RX_DATA <= LINK.a_data;
      end
    end
  end
endmodule

/* verification/ipl_link_properties.sv */
// Checker on the wires between the two link ends
`timescale 1ns/100ps
module ipl_link_properties #(
  parameter int GAP_MIN = 10
) (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic a_strobe,
  input wire logic a_dir,
  input wire logic a_init,
  input wire logic b_strobe,
  input wire logic b_init,
  input wire logic b_xint,
  input wire logic b_present
);
  logic [7:0] gap_cnt;

  // Saturates so a long idle spell never wraps into a false short gap
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      gap_cnt <= 8'hff;
    end else if (a_strobe) begin
      gap_cnt <= 8'h00;
    end else if (gap_cnt != 8'hff) begin
      gap_cnt <= gap_cnt + 8'h01;
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  property p_present; $past(NRST) |-> b_present; endproperty
  a_present: assert property (p_present) else $error("far end not present");
  property p_strobe_pulse; a_strobe |=> !a_strobe; endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");
  property p_strobe_gap; a_strobe |-> gap_cnt >= GAP_MIN; endproperty
  a_strobe_gap: assert property (p_strobe_gap) else $error("words too close");
  property p_strobe_dir; a_strobe |-> !a_dir; endproperty
  a_strobe_dir: assert property (p_strobe_dir) else $error("send while receiver");
  property p_rx_pulse; b_strobe |=> !b_strobe; endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("far strobe too long");
  property p_init_quiet; a_init [*2] |-> !a_strobe; endproperty
  a_init_quiet: assert property (p_init_quiet) else $error("send during init");
  property p_b_init_quiet; b_init [*2] |-> !b_strobe; endproperty
  a_b_init_quiet: assert property (p_b_init_quiet) else $error("far send in init");
  property p_xint_level; $rose(b_xint) |=> b_xint; endproperty
  a_xint_level: assert property (p_xint_level) else $error("cross request glitch");

  c_send: cover property (a_strobe);
  c_far_send: cover property (b_strobe);
  c_far_init: cover property (b_init);
endmodule

/* verification/interprocessor_link_interrupt_status_tb.sv */
// Testbench joining both link ends: status flags, modes, data path
`timescale 1ns/100ps
module interprocessor_link_interrupt_status_tb;
  import ipl_pkg::*;
  localparam int GMIN = 10;
  localparam int GMID = 20;
  localparam int GMAX = 30;
  logic        clock = 1'b0;
  logic        nrst;
  logic        init_a, init_b, stat_wr, data_wr, data_rd, missing, ovf, wc;
  logic        present, xint, dir_b, mode_b, send;
  logic [1:0]  gap_sel;
  logic [15:0] stat_wdata, data_wdata, send_data, stat_rdata, data_rdata, rx_data;
  logic        data_wr_ready, data_rvalid, cycle_end, irq, rx_valid;
  logic [21:0] rows [8];
  int          fails = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          refused;

  ipl_link_if ipl_link_if_inst ();
  ipl_end_a #(.GAP_MIN(GMIN), .GAP_MID(GMID), .GAP_MAX(GMAX)) ipl_end_a_inst (
    .CLOCK(clock), .NRST(nrst), .CE(1'b1), .INIT(init_a), .STAT_WR(stat_wr),
    .STAT_WDATA(stat_wdata), .STAT_RDATA(stat_rdata), .DATA_WR(data_wr),
    .DATA_WDATA(data_wdata), .DATA_WR_READY(data_wr_ready), .DATA_RDATA(data_rdata),
    .DATA_RVALID(data_rvalid), .DATA_RD(data_rd), .MISSING_MEM_EVENT(missing), .ADDR_OVF(ovf),
    .WC_OVF(wc), .TEST_PRESENT(present), .GAP_SEL(gap_sel), .CYCLE_END(cycle_end),
    .IRQ(irq), .LINK(ipl_link_if_inst.end_a));
  ipl_end_b ipl_end_b_inst (
    .CLOCK(clock), .NRST(nrst), .CE(1'b1), .INIT(init_b), .XINT_REQ(xint),
    .DIR(dir_b), .MODE(mode_b), .SEND(send), .SEND_DATA(send_data),
    .RX_DATA(rx_data), .RX_VALID(rx_valid), .LINK(ipl_link_if_inst.end_b));
  ipl_link_properties #(.GAP_MIN(GMIN)) ipl_link_properties_inst (
    .CLOCK(clock), .NRST(nrst), .a_strobe(ipl_link_if_inst.a_strobe),
    .a_dir(ipl_link_if_inst.a_dir), .a_init(ipl_link_if_inst.a_init),
    .b_strobe(ipl_link_if_inst.b_strobe), .b_init(ipl_link_if_inst.b_init),
    .b_xint(ipl_link_if_inst.b_xint), .b_present(ipl_link_if_inst.b_present));

  always #2 clock = ~clock;

  // Cycle ceiling; whole run needs well under a thousand
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr_stat(input logic [15:0] v);
    stat_wdata = v;
    stat_wr = 1'b1;
    tick(1);
    stat_wr = 1'b0;
  endtask

  // Pushes n words while collecting them at the far end
  task automatic burst(input logic [1:0] gs, input int n, input int gap, output int nref);
    int pushed;
    int got;
    int seen;
    int last;
    gap_sel = gs;
    pushed = 0;
    got = 0;
    seen = 0;
    last = 0;
    nref = 0;
    fork
      begin
        while (pushed < n) begin
          data_wdata = 16'ha500 + 16'(pushed);
          data_wr = 1'b1;
          #1;
          if (data_wr_ready) pushed++;
          else nref++;
          tick(1);
        end
        data_wr = 1'b0;
      end
      while (got < n) begin
        tick(1);
        if (cycle_end || ipl_link_if_inst.a_strobe) chk(cycle_end, ipl_link_if_inst.a_strobe);
        if (ipl_link_if_inst.a_strobe) begin
          chk(ipl_link_if_inst.a_data, 16'ha500 + 16'(seen));
          seen++;
        end
        if (rx_valid) begin
          chk(rx_data, 16'ha500 + 16'(got));
          if (got > 0) chk(16'(cyc - last), 16'(gap + 2));
          last = cyc;
          got++;
        end
      end
    join
  endtask

  task automatic conclude;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {nrst, init_a, init_b, stat_wr, data_wr, data_rd, missing, ovf, wc} = 9'h000;
    {xint, dir_b, mode_b, send, gap_sel} = 5'h00;
    present = 1'b1;
    {stat_wdata, data_wdata, send_data} = 48'h0;
    // Row: remote init, module absent, cross request, missing memory, overflow, count done
    rows = '{{6'h04, 16'hc080}, {6'h02, 16'h8080}, {6'h01, 16'h0080}, {6'h08, 16'h0880},
             {6'h10, 16'h8080}, {6'h20, 16'ha080}, {6'h05, 16'hc080}, {6'h0b, 16'h8880}};
    tick(4);
    nrst = 1'b1;
    tick(1);
    chk(stat_rdata, 16'h0080);
    chk({15'h0, irq}, 16'h0000);
    for (int r = 0; r < 8; r++) begin
      wr_stat(16'h0041);
      tick(2);
      chk(stat_rdata & 16'he880, 16'h0000);
      chk({15'h0, irq}, 16'h0000);
      init_b = rows[r][21];
      present = !rows[r][20];
      xint = rows[r][19];
      {missing, ovf, wc} = rows[r][18:16];
      tick(1);
      {missing, ovf, wc} = 3'b000;
      tick(3);
      chk(stat_rdata & 16'he880, rows[r][15:0]);
      chk({15'h0, irq}, 16'h0001);
      {init_b, xint, present} = 3'b001;
      tick(4);
      chk(stat_rdata & 16'h2000, 16'h0000);
    end
    for (int m = 0; m < 4; m++) begin
      {dir_b, mode_b} = 2'(m);
      wr_stat({7'h0, m[0], 4'h0, m[0], 2'(m), 1'b0});
      tick(3);
      chk({14'h0, stat_rdata[10:9]}, 16'(m));
      chk({13'h0, stat_rdata[8], stat_rdata[3], ipl_link_if_inst.a_xint}, {13'h0, {3{m[0]}}});
      chk({14'h0, ipl_link_if_inst.a_dir, ipl_link_if_inst.a_mode}, 16'(m));
    end
    {dir_b, mode_b, missing} = 3'b001;
    tick(1);
    missing = 1'b0;
    init_a = 1'b1;
    tick(3);
    init_a = 1'b0;
    tick(2);
    chk(stat_rdata, 16'h0080);
    // Far end sends one word to us; our direction is receiver
    wr_stat(16'h0004);
    send_data = 16'h3c5a;
    send = 1'b1;
    tick(1);
    send = 1'b0;
    for (int k = 0; k < 20 && !data_rvalid; k++) tick(1);
    chk(data_rdata, 16'h3c5a);
    data_rd = 1'b1;
    tick(1);
    data_rd = 1'b0;
    tick(1);
    chk({15'h0, data_rvalid}, 16'h0000);
    dir_b = 1'b1; // Opposite directions before a block
    wr_stat(16'h0000);
    tick(2);
    burst(2'd0, 12, GMIN, refused);
    chk({15'h0, refused != 0}, 16'h0001);
    burst(2'd1, 2, GMID, refused);
    burst(2'd3, 2, GMAX, refused);
    conclude();
  end
endmodule
